// >>> hdl/fmpf_framer.sv
// fault report packet framer with axi4-lite register slave
`timescale 1ns/10ps
module fmpf_framer #(
   parameter int unsigned PERIOD_CYC = fmpf_pkg::PERIOD_CYC,
   parameter int unsigned QDEPTH     = 15
) (
   input  wire  logic                aclk,
   input  wire  logic                aresetn,
   input  wire  logic                ce,
   input  wire  logic [7:0]          s_awaddr,
   input  wire  logic                s_awvalid,
   output logic                      s_awready,
   input  wire  logic [31:0]         s_wdata,
   input  wire  logic [3:0]          s_wstrb,
   input  wire  logic                s_wvalid,
   output logic                      s_wready,
   output logic [1:0]                s_bresp,
   output logic                      s_bvalid,
   input  wire  logic                s_bready,
   input  wire  logic [7:0]          s_araddr,
   input  wire  logic                s_arvalid,
   output logic                      s_arready,
   output logic [31:0]               s_rdata,
   output logic [1:0]                s_rresp,
   output logic                      s_rvalid,
   input  wire  logic                s_rready,
   output fmpf_pkg::fmpf_byte_t      tx_byte,
   output logic                      tx_valid,
   input  wire  logic                tx_ready,
   output logic                      irq
);

   // ************************************************************
   // helpers
   // ************************************************************
   // one byte through the msb-first crc
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r = c ^ {b, 24'h00_0000};
      for (int i = 0; i < 8; i++) r = {r[30:0], 1'b0} ^ (r[31] ? fmpf_pkg::CRC_POLY : 32'h0000_0000);
      return r;
   endfunction

   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r = o;
      for (int i = 0; i < 4; i++) if (s[i]) r[8*i +: 8] = n[8*i +: 8];
      return r;
   endfunction

   // packet byte at a position; all fields msb first
   function automatic logic [7:0] pick(input logic [5:0] p, input fmpf_pkg::fmpf_snap_t s, input logic [31:0] c);
      logic [327:0] f;  // whole packet, byte 0 on top
      // RQ2: sync pair; RQ3: version; RQ4: date, time; RQ5: microseconds
      // RQ11: one code; RQ14: reserved zero; RQ12: checksum last
      f = {fmpf_pkg::SYNC0, fmpf_pkg::SYNC1, s.version, s.date, s.hms, s.usec,
           s.state, s.queue, s.code, 160'h0, c};
      return f[327 - 8*p -: 8];
   endfunction

   // ************************************************************
   // declarations
   // ************************************************************
   localparam int     IRQ_W = fmpf_pkg::IRQ_W;  // event count
   logic              en_q;          // framer running
   logic [2:0]        health_q;      // unit health code
   logic [7:0]        version_q;     // structure version
   logic [23:0]       date_q;        // year-1900, month, day
   logic [23:0]       hms_q;         // hour, minute, second
   logic [IRQ_W-1:0]  irq_q;         // sticky events
   logic [IRQ_W-1:0]  mask_q;        // event enables
   logic [15:0]       qmem [QDEPTH]; // fault code queue
   logic [3:0]        qcnt_q;        // codes held
   logic [3:0]        qidx_q;        // one-based entry to send
   logic [2:0]        live_q;        // liveness counter
   logic [31:0]       tick_q;        // interval timer
   logic              due_q;         // report owed
   logic [5:0]        cyc_q;         // cycles within a microsecond
   logic [31:0]       usec_q;        // microsecond of second
   fmpf_pkg::fmpf_state_t st_q;      // framer state
   logic [5:0]        pos_q;         // position of byte on output
   fmpf_pkg::fmpf_snap_t snap_q;     // frozen packet fields
   logic [31:0]       crc_q;         // running checksum
   logic [31:0]       crc_d;         // checksum with byte on output
   logic              aw_q, w_q;     // write halves captured
   logic [7:0]        awa_q;         // write address
   logic [31:0]       wd_q;          // write data
   logic [3:0]        ws_q;          // write strobes
   logic              wr_go;         // both halves present
   logic              rd_go;         // read address taken
   logic              tx_fire;       // stream byte taken
   logic              pkt_start;     // new packet begins
   logic              pkt_end;       // last byte taken
   logic [IRQ_W-1:0]  ev;            // events this cycle
   logic [31:0]       rmux;          // read data select
   logic              rhit;          // read address mapped

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   // one write in flight; halves accepted in any order
   assign s_awready = ~aw_q & ~s_bvalid;
   assign s_wready  = ~w_q & ~s_bvalid;
   assign wr_go     = ce & aw_q & w_q & ~s_bvalid;
   assign s_arready = ~s_rvalid;
   assign rd_go     = ce & s_arvalid & ~s_rvalid;

   // capture write address and data halves
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         awa_q <= 8'h00;
         wd_q  <= 32'h0000_0000;
         ws_q  <= 4'h0;
      end else if (ce) begin
         if (s_awvalid && s_awready) begin
            aw_q  <= 1'b1;
            awa_q <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_q  <= 1'b1;
            wd_q <= s_wdata;
            ws_q <= s_wstrb;
         end
         // both halves consumed by the response
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
         end
      end
   end

   // write response, decode error on unmapped word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid <= 1'b0;
         s_bresp  <= fmpf_pkg::RESP_OK;
      end else if (ce) begin
         if (wr_go) begin
            s_bvalid <= 1'b1;
            s_bresp  <= (awa_q <= fmpf_pkg::A_MASK) ? fmpf_pkg::RESP_OK : fmpf_pkg::RESP_DEC;
         end else if (s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // writable control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q      <= 1'b0;
         health_q  <= 3'h0;
         version_q <= fmpf_pkg::VERSION_RST;
         date_q    <= 24'h46_0101;  // 1970-01-01
         hms_q     <= 24'h00_0000;
         mask_q    <= '0;
      end else if (wr_go) begin
         case (awa_q)
            fmpf_pkg::A_CTRL: begin
               en_q     <= ws_q[0] ? wd_q[0] : en_q;
               health_q <= ws_q[1] ? wd_q[10:8] : health_q;
            end
            fmpf_pkg::A_VER:  version_q <= ws_q[0] ? wd_q[7:0] : version_q;
            fmpf_pkg::A_DATE: date_q <= 24'(merge({8'h00, date_q}, wd_q, ws_q));
            fmpf_pkg::A_TIME: hms_q <= 24'(merge({8'h00, hms_q}, wd_q, ws_q));
            fmpf_pkg::A_MASK: mask_q <= ws_q[0] ? wd_q[IRQ_W-1:0] : mask_q;
            default: ;  // push and clear handled by the queue
         endcase
      end
   end

   // read data select; reserved bits read zero
   always_comb begin
      rhit = 1'b1;
      rmux = 32'h0000_0000;
      case (s_araddr)
         fmpf_pkg::A_CTRL: rmux = {21'h0, health_q, 7'h0, en_q};
         fmpf_pkg::A_VER:  rmux = {24'h0, version_q};
         fmpf_pkg::A_DATE: rmux = {8'h0, date_q};
         fmpf_pkg::A_TIME: rmux = {8'h0, hms_q};
         fmpf_pkg::A_PUSH: rmux = {24'h0, qcnt_q, qidx_q};
         fmpf_pkg::A_IRQ:  rmux = {30'h0, irq_q};
         fmpf_pkg::A_MASK: rmux = {30'h0, mask_q};
         fmpf_pkg::A_STAT: rmux = {24'h0, live_q, 3'h0, due_q, st_q};
         default: rhit = 1'b0;
      endcase
   end

   // read answer one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0000_0000;
         s_rresp  <= fmpf_pkg::RESP_OK;
      end else if (ce) begin
         if (rd_go) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rmux;
            s_rresp  <= rhit ? fmpf_pkg::RESP_OK : fmpf_pkg::RESP_DEC;
         end else if (s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // ************************************************************
   // interrupts
   // ************************************************************
   assign ev[fmpf_pkg::B_SENT] = pkt_end;
   assign ev[fmpf_pkg::B_OVF]  = wr_go & (awa_q == fmpf_pkg::A_PUSH) & (qcnt_q == 4'(QDEPTH));

   // sticky bits; a new event beats the read clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= '0;
      end else if (ce) begin
         if (rd_go && s_araddr == fmpf_pkg::A_IRQ) irq_q <= ev;
         else irq_q <= irq_q | ev;
      end
   end

   assign irq = |(irq_q & mask_q);

   // ************************************************************
   // fault queue
   // ************************************************************
   // push, clear and round-robin index; a push never hides an index step
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         qcnt_q <= 4'h0;
         qidx_q <= 4'h0;
      end else if (ce) begin
         if (wr_go && awa_q == fmpf_pkg::A_QCLR) begin
            qcnt_q <= 4'h0;
            qidx_q <= 4'h0;
         end else begin
            if (wr_go && awa_q == fmpf_pkg::A_PUSH && qcnt_q < 4'(QDEPTH)) begin
               qmem[qcnt_q] <= wd_q[15:0];
               qcnt_q       <= qcnt_q + 4'h1;
            end
            // RQ14: next entry, wrap to first
            if (wr_go && awa_q == fmpf_pkg::A_PUSH && qcnt_q == 4'h0) qidx_q <= 4'h1;
            else if (pkt_end && qcnt_q != 4'h0) qidx_q <= (qidx_q >= qcnt_q) ? 4'h1 : qidx_q + 4'h1;
         end
      end
   end

   // ************************************************************
   // time base
   // ************************************************************
   // microsecond of the current second, hardware kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cyc_q  <= 6'h00;
         usec_q <= 32'h0000_0000;
      end else if (ce) begin
         if (cyc_q == 6'(fmpf_pkg::US_CYC - 1)) begin
            cyc_q <= 6'h00;
            // RQ5: wraps after 999999
            usec_q <= (usec_q == fmpf_pkg::USEC_MAX) ? 32'h0 : usec_q + 32'h1;
         end else begin
            cyc_q <= cyc_q + 6'h01;
         end
      end
   end

   // interval timer; a late packet keeps the next one owed
   always_ff @(posedge aclk) begin
      if (!aresetn || !en_q) begin
         tick_q <= 32'h0000_0000;
         due_q  <= 1'b0;
      end else if (ce) begin
         // RQ1: fixed report interval
         if (tick_q == 32'(PERIOD_CYC - 1)) begin
            tick_q <= 32'h0000_0000;
            due_q  <= 1'b1;
         end else begin
            tick_q <= tick_q + 32'h1;
            if (pkt_start) due_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // packet engine
   // ************************************************************
   assign tx_fire   = ce & tx_valid & tx_ready;
   assign pkt_start = ce & (st_q == fmpf_pkg::ST_IDLE) & due_q;
   assign pkt_end   = tx_fire & (pos_q == fmpf_pkg::POS_LAST);

   // RQ12: fold bytes from state through reserved
   assign crc_d = (tx_fire && pos_q >= fmpf_pkg::POS_STATE
                   && pos_q < fmpf_pkg::POS_CRC)
                  ? crc_step(crc_q, tx_byte.data) : crc_q;

   // liveness advances once per report sent
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         live_q <= 3'h0;
      end else if (pkt_end) begin
         // RQ7: wraps modulo eight
         live_q <= live_q + 3'h1;
      end
   end

   // freeze packet fields at packet start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         snap_q <= '0;
      end else if (pkt_start) begin
         snap_q.version <= version_q;
         snap_q.date    <= date_q;
         snap_q.hms     <= hms_q;
         snap_q.usec    <= usec_q;
         // RQ6: health on top, reserved zero
         // RQ7: liveness in low bits
         snap_q.state   <= {health_q, 2'b00, live_q};
         // RQ9: count high; RQ10: index low
         snap_q.queue   <= {qcnt_q, qidx_q};
         // RQ11: code named by the index
         snap_q.code    <= (qcnt_q == 4'h0) ? 16'h0000 : qmem[qidx_q - 4'h1];
      end
   end

   // byte sequencer with registered stream output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q     <= fmpf_pkg::ST_IDLE;
         pos_q    <= 6'h00;
         crc_q    <= fmpf_pkg::CRC_INIT;
         tx_valid <= 1'b0;
         tx_byte  <= '0;
      end else if (ce) begin
         case (st_q)
            fmpf_pkg::ST_IDLE: begin
               if (due_q) begin
                  st_q         <= fmpf_pkg::ST_SEND;
                  pos_q        <= 6'h00;
                  crc_q        <= fmpf_pkg::CRC_INIT;
                  tx_valid     <= 1'b1;
                  // RQ2: first sync byte
                  tx_byte      <= '{data: fmpf_pkg::SYNC0, last: 1'b0};
               end
            end
            fmpf_pkg::ST_SEND: begin
               if (pkt_end) begin
                  st_q     <= fmpf_pkg::ST_IDLE;
                  tx_valid <= 1'b0;
               end else if (tx_fire) begin
                  // stall holds byte while the sink is busy
                  pos_q        <= pos_q + 6'h01;
                  crc_q        <= crc_d;
                  tx_byte <= '{data: pick(pos_q + 6'h01, snap_q, crc_d), last: pos_q + 6'h01 == fmpf_pkg::POS_LAST};
               end
            end
            default: st_q <= fmpf_pkg::ST_IDLE;
         endcase
      end
   end

endmodule // fmpf_framer

// >>> hdl/fmpf_pkg.sv
// constants, types and register map of the fault report packet framer
//
// Behaviour
// RQ1: one fault report every 1000 ms
// RQ2: packet starts with sync bytes EE, DD
// RQ3: third byte is structure version number
// RQ4: six date/time bytes, year-1900 first
// RQ5: four-byte microsecond field, 0 to 999999
// RQ6: state bits 7:5 health, 4:3 reserved
// RQ7: state bits 2:0 wrapping liveness counter
// RQ8: host treats frozen counter as stalled reporter
// RQ9: queue byte bits 7:4 hold count
// RQ10: queue byte bits 3:0 one-based index
// RQ11: one 16-bit fault code per packet
// RQ12: CRC-32/MPEG-2 over state through reserved
// RQ13: host judges fault severity from contents
// RQ14: reserved zero, queue entries sent round-robin
package fmpf_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_HZ     = 50_000_000;  // aclk rate
   localparam int unsigned PERIOD_MS  = 1000;        // report interval
   localparam int unsigned PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
   localparam int unsigned US_CYC     = CLK_HZ / 1_000_000;
   localparam logic [31:0] USEC_MAX   = 32'h000F_423F;  // 999999

   // ************************************************************
   // packet layout
   // ************************************************************
   localparam logic [7:0]  SYNC0      = 8'hEE;
   localparam logic [7:0]  SYNC1      = 8'hDD;
   localparam logic [5:0]  POS_STATE  = 6'h0D;   // first crc byte
   localparam logic [5:0]  POS_CRC    = 6'h25;   // first crc output
   localparam logic [5:0]  POS_LAST   = 6'h28;   // 41 bytes total
   localparam logic [31:0] CRC_POLY   = 32'h04C1_1DB7;
   localparam logic [31:0] CRC_INIT   = 32'hFFFF_FFFF;
   localparam logic [7:0]  VERSION_RST = 8'h01;

   // ************************************************************
   // register map, byte addresses
   // ************************************************************
   localparam logic [7:0] A_CTRL   = 8'h00;  // [0] enable [10:8] health
   localparam logic [7:0] A_VER    = 8'h04;  // [7:0] structure version
   localparam logic [7:0] A_DATE   = 8'h08;  // year, month, day
   localparam logic [7:0] A_TIME   = 8'h0C;  // hour, minute, second
   localparam logic [7:0] A_PUSH   = 8'h10;  // w: push code, r: queue
   localparam logic [7:0] A_QCLR   = 8'h14;  // w: empty the queue
   localparam logic [7:0] A_IRQ    = 8'h18;  // sticky, read clears
   localparam logic [7:0] A_MASK   = 8'h1C;  // interrupt enables
   localparam logic [7:0] A_STAT   = 8'h20;  // busy, liveness
   localparam int         IRQ_W    = 2;      // [0] sent [1] overflow
   localparam int         B_SENT   = 0;
   localparam int         B_OVF    = 1;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_DEC = 2'h3;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } fmpf_state_t;

   // one outgoing stream byte
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } fmpf_byte_t;

   // packet contents frozen at packet start
   typedef struct packed {
      logic [7:0]  version;
      logic [23:0] date;
      logic [23:0] hms;
      logic [31:0] usec;
      logic [7:0]  state;
      logic [7:0]  queue;
      logic [15:0] code;
   } fmpf_snap_t;

endpackage

// >>> tb/fmpf_framer_properties.sv
// concurrent checks on the framer packet stream
`timescale 1ns/10ps
module fmpf_framer_properties (
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic                 ce,
   input wire fmpf_pkg::fmpf_byte_t tx_byte,
   input wire logic                 tx_valid,
   input wire logic                 tx_ready
);
   // ************************************************************
   // byte position tracker
   // ************************************************************
   logic [5:0] idx_q;  // position of the byte on offer
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a byte moves only while ce is high
   sequence s_take;
      tx_valid && tx_ready && ce;
   endsequence
   // last byte of a packet taken
   sequence s_end;
      s_take ##0 tx_byte.last;
   endsequence
   // counts taken bytes, restarts after the last one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idx_q <= 6'h00;
      end else if (tx_valid && tx_ready && ce) begin
         idx_q <= tx_byte.last ? 6'h00 : idx_q + 6'h01;
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   AST_SYNC0: assert property (tx_valid && idx_q == 6'h00 |-> tx_byte.data == 8'hEE)
      else $error("first sync byte wrong");
   AST_SYNC1: assert property (s_take ##0 idx_q == 6'h00 |=> tx_valid && tx_byte.data == 8'hDD)
      else $error("second sync byte wrong");
   AST_RSV: assert property (tx_valid && idx_q == 6'h0D |-> tx_byte.data[4:3] == 2'h0)
      else $error("state reserved bits set");
   AST_ZERO: assert property (tx_valid && idx_q inside {[6'h11:6'h24]} |-> tx_byte.data == 8'h00)
      else $error("reserved byte not zero");
   AST_LAST: assert property (tx_valid |-> tx_byte.last == (idx_q == 6'h28))
      else $error("last flag off the final crc byte");
   AST_GAP: assert property (s_end |=> !tx_valid)
      else $error("no gap after packet");
   AST_HOLD: assert property (tx_valid && !(tx_ready && ce) |=> tx_valid && $stable(tx_byte))
      else $error("stalled byte changed");
   AST_CNT: assert property (tx_valid && idx_q == 6'h0E |->
      ((tx_byte.data[3:0] == 4'h0) == (tx_byte.data[7:4] == 4'h0)) && tx_byte.data[3:0] <= tx_byte.data[7:4])
      else $error("queue index outside count");
endmodule // fmpf_framer_properties
bind fmpf_framer fmpf_framer_properties u_props (.aclk, .aresetn, .ce, .tx_byte, .tx_valid, .tx_ready);

// >>> tb/fmpf_sink.sv
// host side receiver model: stalls on request, logs bytes
`timescale 1ns/10ps
module fmpf_sink (
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire fmpf_pkg::fmpf_byte_t tx_byte,
   input wire logic                 tx_valid,
   input wire logic                 stall,
   output logic                     tx_ready,
   output logic                     stuck,
   output logic                     fault
);
   logic [7:0] got[$];      // received bytes, popped by the bench
   int         starts[$];   // cycle of each packet start
   int         cyc = 0;     // free running cycle count
   int         k = 0;       // byte index within packet
   logic [2:0] prev = 3'h7; // liveness of previous packet
   logic       vq = 1'h0;   // valid one cycle ago
   // ************************************************************
   // receive process
   // ************************************************************
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      vq <= tx_valid;
      // half duty ready while stalling, a slow host
      tx_ready <= !aresetn || !stall || cyc[1];
      if (tx_valid && !vq) begin
         starts.push_back(cyc);
      end
      if (!aresetn) begin
         stuck <= 1'h0;
         fault <= 1'h0;
      end else if (tx_valid && tx_ready) begin
         got.push_back(tx_byte.data);
         k <= tx_byte.last ? 0 : k + 1;
         if (k == 13) begin
            stuck <= tx_byte.data[2:0] == prev;
            prev <= tx_byte.data[2:0];
            fault <= tx_byte.data[7:5] != 3'h0;
         end
      end
   end
endmodule // fmpf_sink

// >>> tb/testbench.sv
// bench: drives registers, predicts packets, compares
`timescale 1ns/10ps
module testbench;
   // ************************************************************
   // signals and helpers
   // ************************************************************
   logic aclk = 1'h0, aresetn = 1'h0, stall = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rq, crc, us, body;
   logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, irq, stuck, fault;
   logic [1:0] bresp, rresp, rr;
   logic [7:0] ver, b, e;
   logic [2:0] hl;              // health for the packet
   logic [23:0] dt, tm;         // date and time written
   logic [103:0] hdr;           // expected bytes 0..12
   logic [15:0] codes[3];       // queued fault codes
   logic [31:0] rs = 32'd36;    // xorshift state
   int fail_count = 0, comparisons = 0, n;
   fmpf_pkg::fmpf_byte_t tx_byte;
   always #10 aclk = ~aclk;
   fmpf_framer #(.PERIOD_CYC(200)) u_fmpf_framer (.aclk, .aresetn, .ce(1'h1), .s_awaddr(awaddr),
      .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
      .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
      .s_rready(rready), .tx_byte, .tx_valid, .tx_ready, .irq);
   fmpf_sink u_fmpf_sink (.aclk, .aresetn, .tx_byte, .tx_valid, .stall, .tx_ready, .stuck, .fault);
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   // msb first crc step, no reflection
   function automatic logic [31:0] crcb(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] x;
      x = c ^ {d, 24'h000000};
      for (int i = 0; i < 8; i++) begin
         x = x[31] ? (x << 1) ^ fmpf_pkg::CRC_POLY : x << 1;
      end
      return x;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("mismatches %0d of %0d checks", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one axi4-lite write (w=1) or read
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, dn;
      int k;
      k = 0;
      dn = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      while (!dn && k < 100) begin
         @(negedge aclk);
         ta = w ? awready : arready;
         tw = wready;
         dn = w ? bvalid : rvalid;
         rq = rdata;
         rr = w ? bresp : rresp;
         k++;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'h0;
            arvalid <= 1'h0;
         end
         if (tw) wvalid <= 1'h0;
         if (dn) begin
            bready <= 1'h0;
            rready <= 1'h0;
         end
      end
      if (!dn) fail_count++;
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      bus(1'h0, fmpf_pkg::A_VER, 32'h0);
      chk("version reset", rq, 32'h1);
      bus(1'h0, fmpf_pkg::A_DATE, 32'h0);
      chk("date reset", rq, 32'h460101);
      bus(1'h0, 8'h40, 32'h0);
      chk("unmapped read", {rq[29:0], rr}, {30'h0, fmpf_pkg::RESP_DEC});
      bus(1'h1, 8'h24, 32'h0);
      chk("unmapped write", rr, fmpf_pkg::RESP_DEC);
      ver = 8'(rnd());
      dt = {8'(70 + rnd() % 50), 8'(1 + rnd() % 12), 8'(1 + rnd() % 28)};
      tm = {8'(rnd() % 24), 8'(rnd() % 60), 8'(rnd() % 60)};
      bus(1'h1, fmpf_pkg::A_VER, {24'h0, ver});
      bus(1'h1, fmpf_pkg::A_DATE, {8'h00, dt});
      bus(1'h1, fmpf_pkg::A_TIME, {8'h00, tm});
      bus(1'h1, fmpf_pkg::A_MASK, 32'h1);
      for (int i = 0; i < 3; i++) begin
         codes[i] = 16'(rnd());
         bus(1'h1, fmpf_pkg::A_PUSH, {16'h0, codes[i]});
      end
      bus(1'h0, fmpf_pkg::A_PUSH, 32'h0);
      chk("queue count", rq, 32'h31);
      // nine packets so the liveness counter wraps
      for (int p = 0; p < 9; p++) begin
         hl = 3'(p % 4);
         stall <= 1'(rnd());
         bus(1'h1, fmpf_pkg::A_CTRL, {21'h0, hl, 8'h01});
         n = 0;
         while (u_fmpf_sink.got.size() < 41 && n < 1000) begin
            @(negedge aclk);
            n++;
         end
         hdr = {8'hEE, 8'hDD, ver, dt, tm, 32'h0};
         body = {hl, 2'h0, 3'(p), 4'h3, 4'(p % 3 + 1), codes[p % 3]};
         crc = fmpf_pkg::CRC_INIT;
         for (int i = 0; i < 41; i++) begin
            b = u_fmpf_sink.got.pop_front();
            e = i < 13 ? hdr[103 - 8 * i -: 8] : i < 17 ? body[31 - 8 * (i - 13) -: 8] : 8'h00;
            if (i >= 37) e = crc[31 - 8 * (i - 37) -: 8];
            if (i >= 13 && i < 37) crc = crcb(crc, e);
            if (i >= 9 && i <= 12) us = {us[23:0], b};
            else chk("packet byte", b, e);
         end
         chk("usec range", us <= fmpf_pkg::USEC_MAX, 32'h1);
         if (p > 0) chk("interval", u_fmpf_sink.starts[p] - u_fmpf_sink.starts[p - 1], 200);
         chk("liveness moves", stuck, 1'h0);
         chk("fault seen", fault, hl != 3'h0);
         chk("irq after packet", irq, 1'h1);
         bus(1'h0, fmpf_pkg::A_IRQ, 32'h0);
         chk("irq status", rq, 32'h1);
         chk("irq cleared", irq, 1'h0);
      end
      // overflow of the 15 deep queue, first masked
      bus(1'h1, fmpf_pkg::A_CTRL, 32'h0);
      repeat (13) bus(1'h1, fmpf_pkg::A_PUSH, 32'h1234);
      chk("masked irq", irq, 1'h0);
      bus(1'h1, fmpf_pkg::A_MASK, 32'h3);
      chk("unmasked irq", irq, 1'h1);
      bus(1'h0, fmpf_pkg::A_IRQ, 32'h0);
      chk("overflow status", rq, 32'h2);
      bus(1'h1, fmpf_pkg::A_QCLR, 32'h0);
      bus(1'h0, fmpf_pkg::A_PUSH, 32'h0);
      chk("queue cleared", rq, 32'h0);
      print_verdict();
   end
   // hang guard, well past nine packets
   initial begin
      #400000;
      fail_count++;
      print_verdict();
   end
endmodule // testbench
